// ===== core/scs_clock_ctrl.sv
`timescale 1ns/1ps
`include "scs_clk_map.svh"

// Function
// - Reset selects the external crystal as the CPU clock source.
// - The crystal feeds a PLL whose nominal 160 MHz output is a CPU source.
// - Software picks crystal, PLL or internal 8 MHz as the CPU source.
// - The CPU clock is the chosen source undivided or through a divider.
// - The RTC mux offers exactly five sources.
// - One RTC source is the fast crystal divided by four.
// - The 31.25 kHz RTC source is the 8 MHz oscillator divided by 256.
// - The roughly 150 kHz RC oscillator has a software frequency trim.
// - The audio PLL output is programmable from 16 MHz to 128 MHz.
// - Audio PLL output is crystal times N over M times two to the K.
module scs_clock_ctrl #(
  parameter int XTAL_KHZ = 40000,
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // Clock sources from pins and analog cells
  input wire logic xtal_clk,
  input wire logic xtal32k_clk,
  input wire logic rc_osc_clk,
  input wire logic osc8m_clk,
  input wire logic pll_clk,
  // PLL and oscillator controls
  output logic pll_en,
  output logic pll_ref_clk,
  output logic [7:0] rc_trim,
  output logic apll_en,
  output logic [7:0] apll_n,
  output logic [4:0] apll_m,
  output logic [2:0] apll_k,
  // Generated clocks
  output logic cpu_clk,
  output logic rtc_clk
);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  localparam int N_SYNC = 5;
  localparam int I_XTAL = 0;
  localparam int I_X32K = 1;
  localparam int I_RC = 2;
  localparam int I_OSC = 3;
  localparam int I_PLL = 4;

  scs_pkg::scs_cpu_cfg_s cpu_cfg_reg;
  scs_pkg::scs_rtc_cfg_s rtc_cfg_reg;
  scs_pkg::scs_apll_cfg_s apll_cfg_reg;
  logic pll_en_reg;
  logic apll_ok_reg;
  logic [31:0] rd_data_reg;

  logic [N_SYNC-1:0] meta_reg;
  logic [N_SYNC-1:0] sync_reg;
  logic [N_SYNC-1:0] prev_reg;
  logic [N_SYNC-1:0] rise;

  logic div4_cnt_reg;
  logic div4_reg;
  logic [6:0] div256_cnt_reg;
  logic div256_reg;

  logic [2:0] cpu_lvl;
  logic [4:0] rtc_lvl;
  logic cpu_mux;
  logic cpu_mux_prev_reg;
  logic [1:0] cpu_active;
  logic cpu_sw;
  logic rtc_mux;
  logic [2:0] rtc_active;
  logic rtc_sw;

  logic [DIV_W-1:0] cpu_cnt_reg;
  logic cpu_clk_reg;
  logic rtc_clk_reg;

  logic [31:0] apll_num;
  logic [31:0] apll_den;
  logic [31:0] cpu_word;
  logic [31:0] rtc_word;
  logic [31:0] apll_word;
  logic [31:0] stat_word;

  ////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic cpu_sel_ok(input logic [1:0] v);
    cpu_sel_ok = (v == scs_pkg::SCS_CPU_XTAL) ||
                 (v == scs_pkg::SCS_CPU_PLL) ||
                 (v == scs_pkg::SCS_CPU_OSC8M);
  endfunction : cpu_sel_ok

  // Only five codes exist; the upper three are refused
  function automatic logic rtc_sel_ok(input logic [2:0] v);
    rtc_sel_ok = (v <= scs_pkg::SCS_RTC_DIV256);
  endfunction : rtc_sel_ok

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////
  // Source synchronisers

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= {pll_clk, osc8m_clk, rc_osc_clk,
                   xtal32k_clk, xtal_clk};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_SYNC; gi = gi + 1) begin : g_rise
      assign rise[gi] = sync_reg[gi] & ~prev_reg[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Fixed prescalers

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div4_cnt_reg <= 1'b0;
      div4_reg <= 1'b0;
    end else if (rise[I_XTAL]) begin
      if (div4_cnt_reg == `SCS_DIV4_LAST) begin
        div4_cnt_reg <= 1'b0;
        div4_reg <= ~div4_reg;
      end else begin
        div4_cnt_reg <= div4_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div256_cnt_reg <= 7'h00;
      div256_reg <= 1'b0;
    end else if (rise[I_OSC]) begin
      if (div256_cnt_reg == `SCS_DIV256_LAST) begin
        div256_cnt_reg <= 7'h00;
        div256_reg <= ~div256_reg;
      end else begin
        div256_cnt_reg <= div256_cnt_reg + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_cfg_reg.src <= scs_pkg::SCS_CPU_XTAL;
      cpu_cfg_reg.div_en <= 1'b0;
      cpu_cfg_reg.div_val <= `SCS_DIV_RST;
    end else if (wr_en && hit(addr, `SCS_CPU_CTRL_OFS)) begin
      if (cpu_sel_ok(wr_data[`SCS_CPU_SEL_LSB +: 2])) begin
        cpu_cfg_reg.src <= scs_pkg::scs_cpu_src_e'(
          wr_data[`SCS_CPU_SEL_LSB +: 2]);
      end
      cpu_cfg_reg.div_en <= wr_data[`SCS_CPU_DIVEN_BIT];
      cpu_cfg_reg.div_val <= wr_data[`SCS_CPU_DIV_LSB +: 8];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rtc_cfg_reg.src <= scs_pkg::SCS_RTC_XTAL32K;
      rtc_cfg_reg.rc_trim <= `SCS_TRIM_RST;
    end else if (wr_en && hit(addr, `SCS_RTC_CTRL_OFS)) begin
      if (rtc_sel_ok(wr_data[`SCS_RTC_SEL_LSB +: 3])) begin
        rtc_cfg_reg.src <= scs_pkg::scs_rtc_src_e'(
          wr_data[`SCS_RTC_SEL_LSB +: 3]);
      end
      rtc_cfg_reg.rc_trim <= wr_data[`SCS_RTC_TRIM_LSB +: 8];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pll_en_reg <= 1'b0;
    end else if (wr_en && hit(addr, `SCS_PLL_CTRL_OFS)) begin
      pll_en_reg <= wr_data[`SCS_PLL_EN_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      apll_cfg_reg.en <= 1'b0;
      apll_cfg_reg.n <= `SCS_APLL_N_RST;
      apll_cfg_reg.m <= `SCS_APLL_M_RST;
      apll_cfg_reg.k <= `SCS_APLL_K_RST;
    end else if (wr_en && hit(addr, `SCS_APLL_CFG_OFS)) begin
      apll_cfg_reg.en <= wr_data[`SCS_APLL_EN_BIT];
      apll_cfg_reg.n <= wr_data[`SCS_APLL_N_LSB +: 8];
      apll_cfg_reg.m <= wr_data[`SCS_APLL_M_LSB +: 5];
      apll_cfg_reg.k <= wr_data[`SCS_APLL_K_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Audio PLL range check

  // Cross-multiplied so no divider is needed; M of zero never passes
  assign apll_num = 32'(XTAL_KHZ) * {24'h000000, apll_cfg_reg.n};
  assign apll_den = {27'h0000000, apll_cfg_reg.m} << apll_cfg_reg.k;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      apll_ok_reg <= 1'b0;
    end else begin
      apll_ok_reg <= (apll_den != 32'h00000000) &&
        (apll_num >= `SCS_APLL_MIN_KHZ * apll_den) &&
        (apll_num <= `SCS_APLL_MAX_KHZ * apll_den);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // CPU clock mux and divider

  // PLL above half of core_clk is only sampled; real silicon needs a
  // dedicated clock cell here
  assign cpu_lvl = {sync_reg[I_OSC], sync_reg[I_PLL],
                    sync_reg[I_XTAL]};

  scs_glitch_mux #(
    .N_SRC(3),
    .SEL_W(2)
  ) u_cpu_mux (
    .core_clk(core_clk),
    .rst(rst),
    .src_lvl(cpu_lvl),
    .sel_req(cpu_cfg_reg.src),
    .clk_out(cpu_mux),
    .sel_active(cpu_active),
    .switching(cpu_sw)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_mux_prev_reg <= 1'b0;
    end else begin
      cpu_mux_prev_reg <= cpu_mux;
    end
  end

  // Divider toggles only on source rising edges, every div_val+1
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_cnt_reg <= '0;
      cpu_clk_reg <= 1'b0;
    end else if (!cpu_cfg_reg.div_en) begin
      cpu_cnt_reg <= '0;
      cpu_clk_reg <= cpu_mux;
    end else if (cpu_mux && !cpu_mux_prev_reg) begin
      if (cpu_cnt_reg >= DIV_W'(cpu_cfg_reg.div_val)) begin
        cpu_cnt_reg <= '0;
        cpu_clk_reg <= ~cpu_clk_reg;
      end else begin
        cpu_cnt_reg <= cpu_cnt_reg + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // RTC clock mux

  assign rtc_lvl = {div256_reg, sync_reg[I_OSC], sync_reg[I_RC],
                    div4_reg, sync_reg[I_X32K]};

  scs_glitch_mux #(
    .N_SRC(5),
    .SEL_W(3)
  ) u_rtc_mux (
    .core_clk(core_clk),
    .rst(rst),
    .src_lvl(rtc_lvl),
    .sel_req(rtc_cfg_reg.src),
    .clk_out(rtc_mux),
    .sel_active(rtc_active),
    .switching(rtc_sw)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rtc_clk_reg <= 1'b0;
    end else begin
      rtc_clk_reg <= rtc_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read port

  always_comb begin
    cpu_word = '0;
    cpu_word[`SCS_CPU_SEL_LSB +: 2] = cpu_cfg_reg.src;
    cpu_word[`SCS_CPU_DIVEN_BIT] = cpu_cfg_reg.div_en;
    cpu_word[`SCS_CPU_DIV_LSB +: 8] = cpu_cfg_reg.div_val;
    rtc_word = '0;
    rtc_word[`SCS_RTC_SEL_LSB +: 3] = rtc_cfg_reg.src;
    rtc_word[`SCS_RTC_TRIM_LSB +: 8] = rtc_cfg_reg.rc_trim;
    apll_word = '0;
    apll_word[`SCS_APLL_N_LSB +: 8] = apll_cfg_reg.n;
    apll_word[`SCS_APLL_M_LSB +: 5] = apll_cfg_reg.m;
    apll_word[`SCS_APLL_K_LSB +: 3] = apll_cfg_reg.k;
    apll_word[`SCS_APLL_EN_BIT] = apll_cfg_reg.en;
    stat_word = '0;
    stat_word[`SCS_ST_CPU_LSB +: 2] = cpu_active;
    stat_word[`SCS_ST_RTC_LSB +: 3] = rtc_active;
    stat_word[`SCS_ST_CPU_SW_BIT] = cpu_sw;
    stat_word[`SCS_ST_RTC_SW_BIT] = rtc_sw;
    stat_word[`SCS_ST_APLL_OK_BIT] = apll_ok_reg;
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= '0;
    end else if (!rd_en) begin
      rd_data_reg <= '0;
    end else if (hit(addr, `SCS_CPU_CTRL_OFS)) begin
      rd_data_reg <= cpu_word;
    end else if (hit(addr, `SCS_RTC_CTRL_OFS)) begin
      rd_data_reg <= rtc_word;
    end else if (hit(addr, `SCS_PLL_CTRL_OFS)) begin
      rd_data_reg <= {31'h00000000, pll_en_reg};
    end else if (hit(addr, `SCS_APLL_CFG_OFS)) begin
      rd_data_reg <= apll_word;
    end else if (hit(addr, `SCS_STATUS_OFS)) begin
      rd_data_reg <= stat_word;
    end else begin
      rd_data_reg <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign rd_data = rd_data_reg;
  assign pll_en = pll_en_reg;
  assign pll_ref_clk = sync_reg[I_XTAL];
  assign rc_trim = rtc_cfg_reg.rc_trim;
  assign apll_en = apll_cfg_reg.en;
  assign apll_n = apll_cfg_reg.n;
  assign apll_m = apll_cfg_reg.m;
  assign apll_k = apll_cfg_reg.k;
  assign cpu_clk = cpu_clk_reg;
  assign rtc_clk = rtc_clk_reg;

endmodule : scs_clock_ctrl

// ===== core/scs_clk_map.svh
`ifndef SCS_CLK_MAP_SVH
`define SCS_CLK_MAP_SVH

// Register offsets
`define SCS_CPU_CTRL_OFS 8'h00
`define SCS_RTC_CTRL_OFS 8'h04
`define SCS_PLL_CTRL_OFS 8'h08
`define SCS_APLL_CFG_OFS 8'h0C
`define SCS_STATUS_OFS 8'h10

// CPU control fields
`define SCS_CPU_SEL_LSB 0
`define SCS_CPU_DIVEN_BIT 2
`define SCS_CPU_DIV_LSB 3

// RTC control fields
`define SCS_RTC_SEL_LSB 0
`define SCS_RTC_TRIM_LSB 8

// PLL control fields
`define SCS_PLL_EN_BIT 0

// Audio PLL fields
`define SCS_APLL_N_LSB 0
`define SCS_APLL_M_LSB 8
`define SCS_APLL_K_LSB 16
`define SCS_APLL_EN_BIT 24

// Status fields
`define SCS_ST_CPU_LSB 0
`define SCS_ST_RTC_LSB 2
`define SCS_ST_CPU_SW_BIT 5
`define SCS_ST_RTC_SW_BIT 6
`define SCS_ST_APLL_OK_BIT 7

// Reset values
`define SCS_DIV_RST 8'h00
`define SCS_TRIM_RST 8'h80
`define SCS_APLL_N_RST 8'h01
`define SCS_APLL_M_RST 5'h01
`define SCS_APLL_K_RST 3'h0

// Fixed prescaler last counts, half periods minus one in source rising edges
`define SCS_DIV4_LAST 1'h1
`define SCS_DIV256_LAST 7'h7F

// Audio PLL output range in kHz
`define SCS_APLL_MIN_KHZ 32'h00003E80
`define SCS_APLL_MAX_KHZ 32'h0001F400

`endif

// ===== core/scs_pkg.sv
package scs_pkg;

  typedef enum logic [1:0] {
    SCS_CPU_XTAL = 2'h0,
    SCS_CPU_PLL = 2'h1,
    SCS_CPU_OSC8M = 2'h2
  } scs_cpu_src_e;

  typedef enum logic [2:0] {
    SCS_RTC_XTAL32K = 3'h0,
    SCS_RTC_XTAL_DIV4 = 3'h1,
    SCS_RTC_RC = 3'h2,
    SCS_RTC_OSC8M = 3'h3,
    SCS_RTC_DIV256 = 3'h4
  } scs_rtc_src_e;

  typedef enum logic [1:0] {
    SCS_SW_RUN = 2'h0,
    SCS_SW_DRAIN = 2'h1,
    SCS_SW_ARM = 2'h2
  } scs_sw_state_e;

  typedef struct packed {
    scs_cpu_src_e src;
    logic div_en;
    logic [7:0] div_val;
  } scs_cpu_cfg_s;

  typedef struct packed {
    scs_rtc_src_e src;
    logic [7:0] rc_trim;
  } scs_rtc_cfg_s;

  typedef struct packed {
    logic en;
    logic [2:0] k;
    logic [4:0] m;
    logic [7:0] n;
  } scs_apll_cfg_s;

endpackage : scs_pkg

// ===== core/scs_glitch_mux.sv
`timescale 1ns/1ps

module scs_glitch_mux #(
  parameter int N_SRC = 3,
  parameter int SEL_W = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Source levels, already synchronised
  input wire logic [N_SRC-1:0] src_lvl,
  input wire logic [SEL_W-1:0] sel_req,
  // Muxed clock and state
  output logic clk_out,
  output logic [SEL_W-1:0] sel_active,
  output logic switching
);

  scs_pkg::scs_sw_state_e state_reg;
  logic [SEL_W-1:0] cur_reg;
  logic [SEL_W-1:0] tgt_reg;
  logic out_reg;

  // Old source must finish its high phase and the new one must be
  // low before it is passed on, so no runt pulse leaves the mux
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= scs_pkg::SCS_SW_RUN;
      cur_reg <= '0;
      tgt_reg <= '0;
    end else begin
      unique case (state_reg)
        scs_pkg::SCS_SW_RUN: begin
          if (sel_req != cur_reg) begin
            state_reg <= scs_pkg::SCS_SW_DRAIN;
          end
        end
        scs_pkg::SCS_SW_DRAIN: begin
          if (!src_lvl[cur_reg]) begin
            tgt_reg <= sel_req;
            state_reg <= scs_pkg::SCS_SW_ARM;
          end
        end
        scs_pkg::SCS_SW_ARM: begin
          if (!src_lvl[tgt_reg]) begin
            cur_reg <= tgt_reg;
            state_reg <= scs_pkg::SCS_SW_RUN;
          end
        end
        default: state_reg <= scs_pkg::SCS_SW_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_reg <= 1'b0;
    end else if (state_reg == scs_pkg::SCS_SW_ARM) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= src_lvl[cur_reg];
    end
  end

  assign clk_out = out_reg;
  assign sel_active = cur_reg;
  assign switching = (state_reg != scs_pkg::SCS_SW_RUN);

endmodule : scs_glitch_mux

// ===== testbench/scs_clock_ctrl_chk.sv
`timescale 1ns/1ps
`include "scs_clk_map.svh"

module scs_clock_ctrl_chk #(
  parameter int XTAL_KHZ = 40000
) (
  // Clock, reset and register port
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  // Clocks and controls
  input wire logic xtal_clk,
  input wire logic pll_ref_clk,
  input wire logic pll_en,
  input wire logic [7:0] rc_trim,
  input wire logic apll_en,
  input wire logic [7:0] apll_n,
  input wire logic [4:0] apll_m,
  input wire logic [2:0] apll_k,
  input wire logic cpu_clk,
  input wire logic rtc_clk
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////
  logic [2:0] up_cnt;
  logic cpu_wr;
  logic div_q;
  logic [3:0] quiet;
  logic [15:0] cfg_d;
  logic [1:0] cfg_age;
  logic [31:0] fx_v, lo_v, hi_v;
  logic apll_ok;
  assign fx_v = 32'(XTAL_KHZ) * 32'(apll_n);
  assign lo_v = (`SCS_APLL_MIN_KHZ * 32'(apll_m)) << apll_k;
  assign hi_v = (`SCS_APLL_MAX_KHZ * 32'(apll_m)) << apll_k;
  assign apll_ok = (apll_m != 5'h00) && (lo_v <= fx_v) && (fx_v <= hi_v);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) up_cnt <= 3'h0;
    else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
  end
  // Divider enable is not glitch-protected, so runts are excused briefly
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_wr <= 1'b0;
      div_q <= 1'b0;
      quiet <= 4'hF;
    end else if (wr_en && addr == `SCS_CPU_CTRL_OFS) begin
      cpu_wr <= 1'b1;
      div_q <= wr_data[2];
      quiet <= (wr_data[2] != div_q) ? 4'h0 : quiet;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_d <= 16'h0000;
      cfg_age <= 2'h0;
    end else begin
      cfg_d <= {apll_k, apll_m, apll_n};
      if ({apll_k, apll_m, apll_n} != cfg_d) cfg_age <= 2'h0;
      else if (cfg_age != 2'h3) cfg_age <= cfg_age + 2'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  a_ref_follows_xtal: assert property (
    up_cnt == 3'h7 |-> pll_ref_clk == $past(xtal_clk, 2))
    else $error("pll reference does not follow crystal");
  a_cpu_default_xtal: assert property (
    up_cnt == 3'h7 && !cpu_wr |-> cpu_clk == $past(xtal_clk, 4))
    else $error("cpu clock not crystal after reset");
  a_pll_en_write: assert property (
    wr_en && addr == `SCS_PLL_CTRL_OFS |=> pll_en == $past(wr_data[0]))
    else $error("pll enable not written");
  a_trim_write: assert property (
    wr_en && addr == `SCS_RTC_CTRL_OFS |=> rc_trim == $past(wr_data[15:8]))
    else $error("rc trim not written");
  a_apll_fields: assert property (
    wr_en && addr == `SCS_APLL_CFG_OFS |=>
    {apll_en, apll_k, apll_m, apll_n} == $past({wr_data[24],
    wr_data[18:16], wr_data[12:8], wr_data[7:0]}))
    else $error("audio pll fields not written");
  a_apll_range: assert property (
    rd_en && addr == `SCS_STATUS_OFS && cfg_age == 2'h3 |=>
    rd_data[7] == $past(apll_ok))
    else $error("audio pll range flag wrong");
  a_cpu_no_runt: assert property (
    quiet == 4'hF && $changed(cpu_clk) |=> $stable(cpu_clk))
    else $error("cpu clock runt pulse");
  a_rtc_no_runt: assert property (
    $changed(rtc_clk) |=> $stable(rtc_clk) [*1])
    else $error("rtc clock runt pulse");
endmodule : scs_clock_ctrl_chk

bind scs_clock_ctrl scs_clock_ctrl_chk #(.XTAL_KHZ(XTAL_KHZ)) u_chk (
  .core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .xtal_clk(xtal_clk),
  .pll_ref_clk(pll_ref_clk), .pll_en(pll_en), .rc_trim(rc_trim),
  .apll_en(apll_en), .apll_n(apll_n), .apll_m(apll_m), .apll_k(apll_k),
  .cpu_clk(cpu_clk), .rtc_clk(rtc_clk));

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`include "scs_clk_map.svh"
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin \
  fail_count++; $display("[FAIL] %0t %s", $time, m); end end

module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h00000000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data, rv;
  // Sources share one counter: half periods 2,4,8,32,64 cycles
  logic [6:0] tick = 7'h00;
  logic pll_en, pll_ref_clk, apll_en, cpu_clk, rtc_clk;
  logic [7:0] rc_trim, apll_n;
  logic [4:0] apll_m;
  logic [2:0] apll_k;
  int fail_count = 0;
  int cmp_count = 0;

  scs_clock_ctrl DUT (.core_clk(core_clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .xtal_clk(tick[2]), .xtal32k_clk(tick[5]), .rc_osc_clk(tick[6]),
    .osc8m_clk(tick[1]), .pll_clk(tick[3]), .pll_en(pll_en),
    .pll_ref_clk(pll_ref_clk), .rc_trim(rc_trim), .apll_en(apll_en),
    .apll_n(apll_n), .apll_m(apll_m), .apll_k(apll_k), .cpu_clk(cpu_clk),
    .rtc_clk(rtc_clk));

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) tick <= tick + 7'h01;
  //////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  // Mux may take a few cycles to leave its run state
  task automatic settle();
    int n;
    repeat (3) @(posedge core_clk);
    for (n = 0; n < 1000; n++) begin
      rd(`SCS_STATUS_OFS, rv);
      if (rv[6:5] === 2'b00) return;
    end
    fail_count++;
    stop_test();
  endtask : settle
  // First half after a change may be partial, so the third is counted
  task automatic measure(input logic r, input int e, input string m);
    int n, k;
    logic v;
    for (k = 0; k < 3; k++) begin
      v = r ? rtc_clk : cpu_clk;
      n = 0;
      while ((r ? rtc_clk : cpu_clk) === v && n < 3000) begin
        @(posedge core_clk);
        #1 n++;
      end
      if (n >= 3000) begin
        fail_count++;
        stop_test();
      end
    end
    `CHK(n, e, m)
  endtask : measure
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] a [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [31:0] e [6] = '{32'h00000000, 32'h00008000, 32'h00000000,
      32'h00000101, 32'h00000080, 32'h00000000};
    for (int i = 0; i < 6; i++) begin
      rd(a[i], rv);
      `CHK(rv, e[i], "reset value")
    end
    `CHK(rc_trim, 8'h80, "trim reset")
    measure(1'b0, 4, "cpu crystal after reset");
  endtask : t_reset
  task automatic t_cpu();
    logic [1:0] s [3] = '{2'h1, 2'h2, 2'h0};
    int h [3] = '{8, 2, 4};
    wr(`SCS_PLL_CTRL_OFS, 32'h00000001);
    `CHK(pll_en, 1'b1, "pll enable")
    for (int i = 0; i < 3; i++) begin
      wr(`SCS_CPU_CTRL_OFS, {30'h0, s[i]});
      settle();
      `CHK(rv[1:0], s[i], "cpu active select")
      measure(1'b0, h[i], "cpu source period");
    end
    wr(`SCS_CPU_CTRL_OFS, 32'h00000003);
    settle();
    `CHK(rv[1:0], 2'h0, "cpu code 3 refused")
    rd(`SCS_CPU_CTRL_OFS, rv);
    `CHK(rv, 32'h00000000, "cpu code 3 readback")
  endtask : t_cpu
  task automatic t_div();
    int d [2] = '{0, 3};
    for (int i = 0; i < 2; i++) begin
      wr(`SCS_CPU_CTRL_OFS, (32'(d[i]) << 3) | 32'h00000006);
      settle();
      measure(1'b0, (d[i] + 1) * 4, "cpu divided period");
    end
    wr(`SCS_CPU_CTRL_OFS, 32'h00000000);
    settle();
  endtask : t_div
  task automatic t_rtc();
    // Crystal by four, RC, 8 MHz, 32 kHz crystal, then 8 MHz by 256
    logic [2:0] s [5] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h4};
    int h [5] = '{16, 64, 2, 32, 512};
    for (int i = 0; i < 5; i++) begin
      wr(`SCS_RTC_CTRL_OFS, {16'h0, {5'h0, s[i]} ^ 8'hA5, 5'h0, s[i]});
      `CHK(rc_trim, {5'h0, s[i]} ^ 8'hA5, "trim")
      settle();
      `CHK(rv[4:2], s[i], "rtc active select")
      measure(1'b1, h[i], "rtc source period");
    end
    wr(`SCS_RTC_CTRL_OFS, 32'h00000005);
    settle();
    `CHK(rv[4:2], 3'h4, "rtc code 5 refused")
    rd(`SCS_RTC_CTRL_OFS, rv);
    `CHK(rv, 32'h00000004, "rtc code 5 readback")
  endtask : t_rtc
  task automatic t_apll();
    logic [15:0] c [8] = '{16'h0101, 16'h0301, 16'h0104, 16'h2104,
      16'h0002, 16'hFFFF, 16'h0510, 16'h0502};
    logic [7:0] ok = 8'hC9;
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {7'h0, 1'(i), 5'h0, c[i][15:13], 3'h0, c[i][12:8], c[i][7:0]};
      wr(`SCS_APLL_CFG_OFS, d);
      `CHK({apll_en, apll_k, apll_m, apll_n}, {d[24], c[i]}, "apll")
      repeat (3) @(posedge core_clk);
      rd(`SCS_APLL_CFG_OFS, rv);
      `CHK(rv, d, "apll readback")
      rd(`SCS_STATUS_OFS, rv);
      `CHK(rv[7], ok[i], "apll range flag")
    end
  endtask : t_apll
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_cpu();
    t_div();
    t_rtc();
    t_apll();
    stop_test();
  end
endmodule : testbench
